// file: logic/sync_io_pkg.sv
package sync_io_pkg;
	// clock rate
	localparam int unsigned CLK_HZ            = 10_000_000;
	localparam int unsigned CLK_PERIOD_NS     = 1_000_000_000 / CLK_HZ;
	// settle-done timing
	localparam int unsigned SETTLE_WAIT_MS    = 10;
	localparam int unsigned SETTLE_WAIT_CYC   = SETTLE_WAIT_MS * 1_000_000 / CLK_PERIOD_NS;
	localparam int unsigned DONE_PULSE_US     = 10;
	localparam int unsigned DONE_PULSE_CYC    = DONE_PULSE_US * 1_000 / CLK_PERIOD_NS;
	// input qualification: shorter than the 10 us least pulse
	localparam int unsigned MIN_PULSE_US      = 10;
	localparam int unsigned FILTER_NS         = 400;
	localparam int unsigned FILTER_CYC        = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// longest delays to the chain outputs
	localparam int unsigned TRIG_DELAY_NS     = 1_000;
	localparam int unsigned TRIG_DELAY_CYC    = TRIG_DELAY_NS / CLK_PERIOD_NS;
	localparam int unsigned ENABLE_DELAY_MS   = 20;
	localparam int unsigned ENABLE_DELAY_CYC  = ENABLE_DELAY_MS * 1_000_000 / CLK_PERIOD_NS;
	// counter widths for the long waits and the input filter
	localparam int unsigned CNT_W             = 20;
	localparam int unsigned FILT_W            = 4;

	// rear output terminal sources
	typedef enum logic [1:0] {
		OUT_SRC_BUSY   = 2'h0,
		OUT_SRC_ENABLE = 2'h1,
		OUT_SRC_READY  = 2'h2
	} rear_out_source_select_t;

	// rear input terminal functions
	typedef enum logic {
		IN_FN_STEP   = 1'h0,
		IN_FN_ENABLE = 1'h1
	} rear_in_function_select_t;

	// idle levels of the active-low lines
	localparam logic LINE_IDLE = 1'h1;
	localparam logic LINE_ACT  = 1'h0;
endpackage

// file: logic/input_qualifier.sv
`timescale 1ns/10ps
// two-flop synchroniser plus stability filter and edge pulses
module input_qualifier #(
	parameter int unsigned FILTER_LEN = sync_io_pkg::FILTER_CYC
) (
	input  wire logic ref_clk,   // system clock
	input  wire logic rst,       // sync reset, high
	input  wire logic clk_en,    // freezes state when low
	input  wire logic line_in,   // raw active-low line
	output logic      level,     // filtered level
	output logic      fall,      // one-cycle falling edge
	output logic      rise       // one-cycle rising edge
);
	import sync_io_pkg::*;

	logic              sync1;
	logic              sync2;
	logic [FILT_W-1:0] cnt;
	logic              next_level;
	logic [FILT_W-1:0] next_cnt;
	logic              next_fall;
	logic              next_rise;

	////////////////////////////////////////////////////////////////
	// filter: level changes only after FILTER_LEN steady samples
	always_comb begin
		next_level = level;
		next_cnt   = '0;
		next_fall  = 1'b0;
		next_rise  = 1'b0;
		if (sync2 != level) begin
			next_cnt = cnt + 1'b1;
			if (cnt >= FILT_W'(FILTER_LEN - 1)) begin
				next_level = sync2;
				next_cnt   = '0;
				next_fall  = !sync2;
				next_rise  = sync2;
			end
		end
	end

	// sync1 feeds sync2 only, so metastability never reaches the filter
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sync1 <= LINE_IDLE;
			sync2 <= LINE_IDLE;
			level <= LINE_IDLE;
			cnt   <= '0;
			fall  <= 1'b0;
			rise  <= 1'b0;
		end else if (clk_en) begin
			sync1 <= line_in;
			sync2 <= sync1;
			level <= next_level;
			cnt   <= next_cnt;
			fall  <= next_fall;
			rise  <= next_rise;
		end
	end
endmodule

// file: logic/settle_timer.sv
`timescale 1ns/10ps
// waits after a level change, then gives one active-low pulse
module settle_timer #(
	parameter int unsigned WAIT_CYC  = sync_io_pkg::SETTLE_WAIT_CYC,
	parameter int unsigned PULSE_CYC = sync_io_pkg::DONE_PULSE_CYC
) (
	input  wire logic ref_clk,     // system clock
	input  wire logic rst,         // sync reset, high
	input  wire logic clk_en,      // freezes state when low
	input  wire logic level_chg,   // source level changed, pulse
	output logic      done_n       // settle-done, active low
);
	import sync_io_pkg::*;

	typedef enum {S_IDLE, S_WAIT, S_PULSE} settle_state_t;

	settle_state_t    state;
	settle_state_t    next_state;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic             next_done_n;

	////////////////////////////////////////////////////////////////
	// a new change restarts the wait, so only the last change is reported
	always_comb begin
		next_state  = state;
		next_cnt    = cnt;
		next_done_n = LINE_IDLE;
		case (state)
			S_IDLE: begin
				next_cnt = '0;
			end
			S_WAIT: begin
				next_cnt = cnt + 1'b1;
				if (cnt >= CNT_W'(WAIT_CYC - 1)) begin
					next_state  = S_PULSE;
					next_cnt    = '0;
					next_done_n = LINE_ACT;
				end
			end
			S_PULSE: begin
				next_done_n = LINE_ACT;
				next_cnt    = cnt + 1'b1;
				if (cnt >= CNT_W'(PULSE_CYC - 1)) begin
					next_state  = S_IDLE;
					next_cnt    = '0;
					next_done_n = LINE_IDLE;
				end
			end
			default: begin
				next_state = S_IDLE;
				next_cnt   = '0;
			end
		endcase
		if (level_chg) begin
			next_state  = S_WAIT;
			next_cnt    = '0;
			next_done_n = LINE_IDLE;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state  <= S_IDLE;
			cnt    <= '0;
			done_n <= LINE_IDLE;
		end else if (clk_en) begin
			state  <= next_state;
			cnt    <= next_cnt;
			done_n <= next_done_n;
		end
	end
endmodule

// file: logic/sync_io_terminal_logic.sv
`timescale 1ns/10ps
module sync_io_terminal_logic #(
	parameter int unsigned FILTER_LEN = sync_io_pkg::FILTER_CYC,
	parameter int unsigned WAIT_CYC   = sync_io_pkg::SETTLE_WAIT_CYC,
	parameter int unsigned PULSE_CYC  = sync_io_pkg::DONE_PULSE_CYC
) (
	input  wire logic                                 ref_clk,                 // 10 MHz system clock
	input  wire logic                                 rst,                     // sync reset, high
	input  wire logic                                 clk_en,                  // freezes all state when low
	// settings
	input  wire sync_io_pkg::rear_out_source_select_t rear_out_source_select,  // rear out source
	input  wire sync_io_pkg::rear_in_function_select_t rear_in_function_select, // rear in function
	// rear single-line terminals
	input  wire logic                                 rear_in_n,               // rear input, active low
	output logic                                      rear_out_n,              // rear output, active low
	// chain input port
	input  wire logic                                 chain_enable_in_n,       // enable control in
	input  wire logic                                 chain_step_in_n,         // step trigger in
	// chain output port
	output logic                                      chain_enable_out_n,      // enable state, low = on
	output logic                                      chain_busy_out_n,        // busy indicator, low = busy
	output logic                                      chain_done_out_n,        // settle-done pulse
	// instrument core side
	input  wire logic                                 local_trigger,           // trigger from core, pulse
	input  wire logic                                 source_op_done,          // source operation done, pulse
	input  wire logic                                 level_changed,           // source level changed, pulse
	input  wire logic                                 local_output_on,         // core asks output on, pulse
	input  wire logic                                 local_output_off,        // core asks output off, pulse
	output logic                                      step_request,            // advance program, pulse
	output logic                                      output_on                // source output state
);
	import sync_io_pkg::*;

	logic rear_level;
	logic rear_fall;
	logic rear_rise;
	logic chain_en_level;
	logic chain_en_fall;
	logic chain_en_rise;
	logic step_level;
	logic step_fall;
	logic step_rise;
	logic settle_done_n;

	logic source_busy_indicator;
	logic next_source_busy_indicator;
	logic next_output_on;
	logic next_step_request;
	logic next_rear_out_n;
	logic next_enable_out_n;

	logic step_event;
	logic enable_on_event;
	logic enable_off_event;

	////////////////////////////////////////////////////////////////
	// input qualification, one per physical input line
	input_qualifier #(
		.FILTER_LEN (FILTER_LEN)
	) u_rear_in (
		.ref_clk (ref_clk),
		.rst     (rst),
		.clk_en  (clk_en),
		.line_in (rear_in_n),
		.level   (rear_level),
		.fall    (rear_fall),
		.rise    (rear_rise)
	);

	input_qualifier #(
		.FILTER_LEN (FILTER_LEN)
	) u_chain_enable_in (
		.ref_clk (ref_clk),
		.rst     (rst),
		.clk_en  (clk_en),
		.line_in (chain_enable_in_n),
		.level   (chain_en_level),
		.fall    (chain_en_fall),
		.rise    (chain_en_rise)
	);

	input_qualifier #(
		.FILTER_LEN (FILTER_LEN)
	) u_chain_step_in (
		.ref_clk (ref_clk),
		.rst     (rst),
		.clk_en  (clk_en),
		.line_in (chain_step_in_n),
		.level   (step_level),
		.fall    (step_fall),
		.rise    (step_rise)
	);

	////////////////////////////////////////////////////////////////
	// settle-done pulse generator
	settle_timer #(
		.WAIT_CYC  (WAIT_CYC),
		.PULSE_CYC (PULSE_CYC)
	) u_settle (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.clk_en    (clk_en),
		.level_chg (level_changed),
		.done_n    (settle_done_n)
	);

	////////////////////////////////////////////////////////////////
	// input routing; both ports are merged, a clash is the driver's fault
	assign step_event = step_fall
		|| (rear_fall && rear_in_function_select == IN_FN_STEP);
	assign enable_on_event = chain_en_fall
		|| (rear_fall && rear_in_function_select == IN_FN_ENABLE);
	assign enable_off_event = chain_en_rise
		|| (rear_rise && rear_in_function_select == IN_FN_ENABLE);

	////////////////////////////////////////////////////////////////
	// output state and busy indicator
	always_comb begin
		next_output_on = output_on;
		if (enable_off_event || local_output_off) begin
			next_output_on = 1'b0;
		end
		// on wins a same-cycle clash, the newer falling edge
		if (enable_on_event || local_output_on) begin
			next_output_on = 1'b1;
		end
		next_source_busy_indicator = source_busy_indicator;
		if (source_op_done) begin
			next_source_busy_indicator = 1'b0;
		end
		// a new trigger beats completion in the same cycle
		if (step_event || local_trigger) begin
			next_source_busy_indicator = 1'b1;
		end
		next_step_request = step_event;
	end

	////////////////////////////////////////////////////////////////
	// output line levels, registered for clean edges
	always_comb begin
		next_enable_out_n = next_output_on ? LINE_ACT : LINE_IDLE;
		case (rear_out_source_select)
			OUT_SRC_BUSY: begin
				next_rear_out_n = !next_source_busy_indicator;
			end
			OUT_SRC_ENABLE: begin
				next_rear_out_n = next_enable_out_n;
			end
			OUT_SRC_READY: begin
				next_rear_out_n = settle_done_n;
			end
			default: begin
				next_rear_out_n = LINE_IDLE;
			end
		endcase
	end

	// busy reaches its pin one flop after the filtered edge, well inside 1 us
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			output_on             <= 1'b0;
			source_busy_indicator <= 1'b0;
			step_request          <= 1'b0;
			chain_enable_out_n    <= LINE_IDLE;
			chain_busy_out_n      <= LINE_IDLE;
			rear_out_n            <= LINE_IDLE;
		end else if (clk_en) begin
			output_on             <= next_output_on;
			source_busy_indicator <= next_source_busy_indicator;
			step_request          <= next_step_request;
			chain_enable_out_n    <= next_enable_out_n;
			chain_busy_out_n      <= !next_source_busy_indicator;
			rear_out_n            <= next_rear_out_n;
		end
	end

	// settle-done has its own dedicated chain line
	assign chain_done_out_n = settle_done_n;
endmodule

// file: test/sync_io_checker_asserts.sv
`timescale 1ns/10ps
module sync_io_checker #(
	parameter int unsigned WAIT_CYC = sync_io_pkg::SETTLE_WAIT_CYC
) (
	input wire logic                                 ref_clk,                // clock
	input wire logic                                 rst,                    // reset
	input wire logic                                 clk_en,                 // clock enable
	input wire sync_io_pkg::rear_out_source_select_t rear_out_source_select, // rear source
	input wire logic                                 chain_step_in_n,        // step in
	input wire logic                                 chain_enable_in_n,      // enable in
	input wire logic                                 rear_out_n,             // rear out
	input wire logic                                 chain_enable_out_n,     // enable out
	input wire logic                                 chain_busy_out_n,       // busy out
	input wire logic                                 chain_done_out_n,       // done out
	input wire logic                                 local_trigger,          // core trigger
	input wire logic                                 source_op_done,         // core done
	input wire logic                                 level_changed,          // level change
	input wire logic                                 step_request,           // step pulse
	input wire logic                                 output_on               // output state
);
	import sync_io_pkg::*;
	logic [31:0] since;
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	// cycles since the last level change; saturates so a stray pulse fails
	always_ff @(posedge ref_clk) begin
		if (rst)
			since <= 32'hFFFF_FFFF;
		else if (level_changed)
			since <= 32'h0000_0000;
		else if (since != 32'hFFFF_FFFF)
			since <= since + 32'h0000_0001;
	end
	////////////////////////////////////////////////////////////////
	busy_set_a: assert property (local_trigger && clk_en |=> !chain_busy_out_n)
		else $error("busy did not follow trigger");
	busy_clear_a: assert property ($rose(chain_busy_out_n) |-> $past(source_op_done))
		else $error("busy cleared without done");
	enable_state_a: assert property (chain_enable_out_n == !output_on)
		else $error("enable line disagrees with state");
	step_pulse_a: assert property (step_request |=> !step_request)
		else $error("step request longer than one cycle");
	step_delay_a: assert property ($fell(chain_step_in_n) ##1 !chain_step_in_n [*7] |-> ##[0:2] !chain_busy_out_n)
		else $error("step slow to reach busy");
	enable_on_a: assert property ($fell(chain_enable_in_n) ##1 !chain_enable_in_n [*7] |-> ##[0:2] output_on)
		else $error("enable fall did not turn on");
	enable_off_a: assert property ($rose(chain_enable_in_n) ##1 chain_enable_in_n [*7] |-> ##[0:2] !output_on)
		else $error("enable rise did not turn off");
	done_wait_a: assert property ($fell(chain_done_out_n) |-> since + 2 >= WAIT_CYC && since <= WAIT_CYC + 2)
		else $error("settle pulse at wrong time");
	done_width_a: assert property ($fell(chain_done_out_n) |-> !chain_done_out_n [*4])
		else $error("settle pulse too short");
	rear_enable_a: assert property (rear_out_source_select == OUT_SRC_ENABLE && $stable(rear_out_source_select)
		|-> rear_out_n == chain_enable_out_n)
		else $error("rear out not showing enable state");
	step_seen_c: cover property (step_request);
	done_seen_c: cover property ($fell(chain_done_out_n));
	on_seen_c: cover property ($rose(output_on));
endmodule

bind sync_io_terminal_logic sync_io_checker #(.WAIT_CYC(WAIT_CYC)) sync_io_checker_inst (
	.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .rear_out_source_select(rear_out_source_select),
	.chain_step_in_n(chain_step_in_n), .chain_enable_in_n(chain_enable_in_n), .rear_out_n(rear_out_n),
	.chain_enable_out_n(chain_enable_out_n), .chain_busy_out_n(chain_busy_out_n),
	.chain_done_out_n(chain_done_out_n), .local_trigger(local_trigger), .source_op_done(source_op_done),
	.level_changed(level_changed), .step_request(step_request), .output_on(output_on));

// file: test/far_unit_model.sv
`timescale 1ns/10ps
// upstream unit or controller driving the chain and rear inputs
module far_unit_model (
	input  wire logic ref_clk,  // system clock
	output logic      step_n,   // step trigger line
	output logic      enable_n, // enable control line
	output logic      rear_n    // rear terminal line
);
	// lines idle high, active low
	initial begin
		step_n = 1'b1;
		enable_n = 1'b1;
		rear_n = 1'b1;
	end
	// one line at a time, so no function is driven on both ports
	task automatic drive(input int sel, input logic val, input int len);
		@(posedge ref_clk);
		case (sel)
			0: step_n <= val;
			1: enable_n <= val;
			default: rear_n <= val;
		endcase
		repeat (len) @(posedge ref_clk);
	endtask
endmodule

// file: test/sync_io_terminal_logic_tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; $display("ERROR %0t mismatch line %0d", $time, `__LINE__); end end
module sync_io_terminal_logic_tb;
	import sync_io_pkg::*;
	localparam int unsigned WAIT  = 50;
	localparam int unsigned PULSE = 5;
	logic                     ref_clk = 1'b0;
	logic                     rst = 1'b1;
	logic                     en = 1'b1;
	rear_out_source_select_t  osel = OUT_SRC_BUSY;
	rear_in_function_select_t isel = IN_FN_STEP;
	logic [4:0]               core = 5'h00;
	logic                     rear_out_n, en_out_n, busy_n, done_n, step_req, out_on, step_n, en_n, rear_n;
	int                       fail_count = 0;
	int                       check_count = 0;
	int                       step_cnt = 0;
	int                       cycles = 0;
	int                       i;

	sync_io_terminal_logic #(.WAIT_CYC(WAIT), .PULSE_CYC(PULSE)) sync_io_terminal_logic_inst (
		.ref_clk(ref_clk), .rst(rst), .clk_en(en), .rear_out_source_select(osel),
		.rear_in_function_select(isel), .rear_in_n(rear_n), .rear_out_n(rear_out_n),
		.chain_enable_in_n(en_n), .chain_step_in_n(step_n), .chain_enable_out_n(en_out_n),
		.chain_busy_out_n(busy_n), .chain_done_out_n(done_n), .local_trigger(core[0]),
		.source_op_done(core[1]), .level_changed(core[2]), .local_output_on(core[3]),
		.local_output_off(core[4]), .step_request(step_req), .output_on(out_on));
	far_unit_model far_unit_model_inst (.ref_clk(ref_clk), .step_n(step_n), .enable_n(en_n), .rear_n(rear_n));

	always #50 ref_clk = ~ref_clk;
	// step pulse tally and a cycle ceiling well past the whole run
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (step_req === 1'b1)
			step_cnt <= step_cnt + 1;
		if (cycles == 20000) begin
			fail_count++;
			stop_test();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("checks %0d errors %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// one-cycle core pulse: 0 trig, 1 done, 2 level, 3 on, 4 off
	task automatic pulse_core(input int k);
		@(posedge ref_clk);
		core <= 5'h01 << k;
		@(posedge ref_clk);
		core <= 5'h00;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask
	task automatic t_step();
		@(posedge ref_clk);
		osel <= OUT_SRC_BUSY;
		far_unit_model_inst.drive(0, 1'b0, 10);
		#1;
		`CHK(busy_n, 1'b0)
		`CHK(rear_out_n, 1'b0)
		far_unit_model_inst.drive(0, 1'b0, 90);
		far_unit_model_inst.drive(0, 1'b1, 20);
		`CHK(step_cnt, 1)
		pulse_core(1);
		`CHK(busy_n, 1'b1)
		`CHK(rear_out_n, 1'b1)
		pulse_core(0);
		`CHK(busy_n, 1'b0)
		pulse_core(1);
	endtask
	// too short for the filter, so nothing may happen
	task automatic t_glitch();
		far_unit_model_inst.drive(0, 1'b0, 1);
		far_unit_model_inst.drive(0, 1'b1, 20);
		`CHK(step_cnt, 1)
		`CHK(busy_n, 1'b1)
	endtask
	task automatic t_enable();
		@(posedge ref_clk);
		osel <= OUT_SRC_ENABLE;
		far_unit_model_inst.drive(1, 1'b0, 150);
		#1;
		`CHK({out_on, en_out_n, rear_out_n}, 3'h4)
		far_unit_model_inst.drive(1, 1'b1, 150);
		#1;
		`CHK({out_on, en_out_n, rear_out_n}, 3'h3)
		pulse_core(3);
		`CHK(out_on, 1'b1)
		pulse_core(4);
		`CHK(en_out_n, 1'b1)
	endtask
	task automatic t_rear();
		far_unit_model_inst.drive(2, 1'b0, 100);
		far_unit_model_inst.drive(2, 1'b1, 20);
		`CHK(step_cnt, 2)
		pulse_core(1);
		isel <= IN_FN_ENABLE;
		far_unit_model_inst.drive(2, 1'b0, 100);
		#1;
		`CHK(out_on, 1'b1)
		`CHK(step_cnt, 2)
		far_unit_model_inst.drive(2, 1'b1, 100);
		#1;
		`CHK(out_on, 1'b0)
	endtask
	// wait then one low pulse, also seen on the rear output
	task automatic t_settle();
		@(posedge ref_clk);
		osel <= OUT_SRC_READY;
		pulse_core(2);
		for (i = 0; i < 200 && done_n === 1'b1; i++) begin
			@(posedge ref_clk);
			#1;
		end
		`CHK(i + 3 >= WAIT && i <= WAIT, 1'b1)
		@(posedge ref_clk);
		#1;
		`CHK(rear_out_n, 1'b0)
		for (i = 0; i < 50 && done_n === 1'b0; i++) begin
			@(posedge ref_clk);
			#1;
		end
		`CHK(i + 2 >= PULSE && i <= PULSE, 1'b1)
	endtask
	// frozen enable drops a trigger; unused select code keeps the rear line idle
	task automatic t_freeze();
		@(posedge ref_clk);
		en <= 1'b0;
		osel <= rear_out_source_select_t'(2'h3);
		pulse_core(0);
		`CHK({busy_n, rear_out_n}, 2'h3)
		en <= 1'b1;
		pulse_core(0);
		`CHK({busy_n, rear_out_n}, 2'h1)
		pulse_core(1);
		`CHK(busy_n, 1'b1)
	endtask
	initial begin
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		#1;
		`CHK({rear_out_n, en_out_n, busy_n, done_n, out_on, step_req}, 6'h3C)
		t_step();
		t_glitch();
		t_enable();
		t_rear();
		t_settle();
		t_freeze();
		stop_test();
	end
endmodule
